// ### hw/ppc_pkg.sv
/*
  Shared constants for the four-port power controller: command codes,
  field layouts, reset values, timing counts and host register map.
  Assumes a 100 MHz system clock on both ends.
*/
// Functional notes
// - Port turn-off clears power-good and port-on
// - Power-good latches on; clears only at turn-off
// - Status byte: good flags high, on flags low
// - Address byte: standalone bit over 7-bit address
// - Host avoids addresses 0x00, 0x30, 0x0C; ppc_host sends to any target, and the device answers 0x30 and 0x0C
// - Standalone bit sampled only after reset
// - Standalone bit selects field reset values
// - Mode register: 2 bits per port
// - Off, manual, semi-auto, auto behaviours
// - Host waits 1.2 ms before enable write
// - Host checks power-good before mode off; ppc_host forwards mode writes without reading the power flags
// - Unplug timer times out, port off, fault
// - Timer reset by long current; floor zero
// - Enable register: classify high, probe low
// - Manual enable runs one cycle, self-clears
// - Power-off command clears both enables
// - Semi-auto repeats probe, classify after valid
// - Auto powers on unless classification bad
// - Enable writes held during cool-down
// - Fast-off input powers off selected ports
// - Host keeps priority low bits zero
package ppc_pkg;
  localparam int NPORT = 4;
  localparam logic [7:0] REG_POWER_FLAGS = 8'h10;
  localparam logic [7:0] REG_BUS_ADDR = 8'h11;
  localparam logic [7:0] REG_MODES = 8'h12;
  localparam logic [7:0] REG_UNPLUG = 8'h13;
  localparam logic [7:0] REG_PROBE_CLASS = 8'h14;
  localparam logic [7:0] REG_FAST_OFF = 8'h15;
  localparam logic [7:0] REG_RESTART = 8'h18;
  localparam logic [7:0] REG_POWER_CMD = 8'h19;
  localparam logic [7:0] REG_RESET_CMD = 8'h1A;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_SEMI = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam int CLASS_LSB = 4;
  localparam int ADDR_SEL_BIT = 3;
  localparam logic [6:0] BROADCAST_ADDR = 7'h30;
  localparam logic [6:0] ALERT_ADDR = 7'h0C;
  localparam logic [7:0] RST_SA_MODES = 8'hFF;
  localparam logic [3:0] RST_SA_UNPLUG = 4'hF;
  localparam logic [7:0] RST_SA_PROBE = 8'hFF;
  localparam logic [3:0] RST_SA_FAST = 4'h0;
  localparam logic [7:0] RST_HOST_MODES = 8'h00;
  localparam logic [3:0] RST_HOST_UNPLUG = 4'h0;
  localparam logic [7:0] RST_HOST_PROBE = 8'h00;
  localparam logic [3:0] RST_HOST_FAST = 4'h0;
  localparam int CLK_HZ = 100_000_000;
  localparam int UNPLUG_WINDOW_MS = 360;
  localparam int UNPLUG_WINDOW_CYC = UNPLUG_WINDOW_MS * (CLK_HZ / 1000);
  localparam int UNPLUG_RESET_PCT = 13;
  localparam int GUARD_US = 1200;
  localparam int GUARD_CYC = GUARD_US * (CLK_HZ / 1_000_000);
  localparam logic [2:0] HREG_TARGET = 3'h0;
  localparam logic [2:0] HREG_CODE = 3'h1;
  localparam logic [2:0] HREG_DATA = 3'h2;
  localparam logic [2:0] HREG_CTRL = 3'h3;
  localparam logic [2:0] HREG_RDATA = 3'h4;
  localparam int CTRL_GO_WR = 0;
  localparam int CTRL_GO_RD = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_DONE = 2;
  typedef enum {SEQ_IDLE, SEQ_PROBE, SEQ_CLASSIFY} ppc_seq_type;
  typedef enum {HOST_IDLE, HOST_GUARD, HOST_WAIT, HOST_RESP} ppc_host_type;
endpackage : ppc_pkg

// ### hw/ppc_if.sv
/*
  Command link between the host controller and the power controller.
  Assumes both ends share clk; the testbench instantiates and joins it.
*/
`timescale 1ns/1ps
interface ppc_if;
  logic req;
  logic wr;
  logic [6:0] addr;
  logic [7:0] code;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport host (output req, wr, addr, code, wdata, input ack, rdata);
  modport device (input req, wr, addr, code, wdata, output ack, rdata);
endinterface : ppc_if

// ### hw/ppc_port.sv
/*
  One port: probe/classify sequencer and unplug delay timer.
  Assumes enables and results come from logic on the same clock.
*/
`timescale 1ns/1ps
module ppc_port import ppc_pkg::*; #(
  parameter int WINDOW_CYC = UNPLUG_WINDOW_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire logic [1:0] mode, // Operating mode
  input wire logic probe_en, // Probe enable
  input wire logic class_en, // Classify enable
  input wire logic powered, // Port is on
  input wire logic cooldown, // Cool-down running
  input wire logic current_above, // Current above unplug threshold
  input wire logic unplug_watch, // Unplug watch enabled
  input wire logic probe_done, // Probe finished
  input wire logic probe_valid, // Probe saw valid resistance
  input wire logic class_done, // Classification finished
  input wire logic class_bad, // Unknown, overcurrent or mismatch
  output logic probe_start_q, // Start a probe
  output logic class_start_q, // Start a classification
  output logic power_on_q, // Request auto power-on
  output logic probe_clear_q, // Manual probe finished
  output logic class_clear_q, // Manual classify finished
  output logic timeout_q // Unplug timeout
);
  localparam int RESET_CYC = (WINDOW_CYC * UNPLUG_RESET_PCT + 99) / 100;
  ppc_seq_type state_q;
  logic [31:0] below_q;
  logic [31:0] above_q;
  logic abort;
  logic manual;
  logic settling;

  assign manual = (mode == MODE_MANUAL);
  assign abort = (mode == MODE_OFF) || powered || cooldown;
  // A clear pulse reaches the enables, and a power-on pulse reaches powered, one edge late; idle must
  // not mistake the stale enable for a fresh request
  assign settling = probe_clear_q || class_clear_q || power_on_q;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= SEQ_IDLE;
      probe_start_q <= 1'b0;
      class_start_q <= 1'b0;
      power_on_q <= 1'b0;
      probe_clear_q <= 1'b0;
      class_clear_q <= 1'b0;
    end else begin
      probe_start_q <= 1'b0;
      class_start_q <= 1'b0;
      power_on_q <= 1'b0;
      probe_clear_q <= 1'b0;
      class_clear_q <= 1'b0;
      case (state_q)
        SEQ_IDLE: begin
          if (!abort && !settling && probe_en) begin
            probe_start_q <= 1'b1;
            state_q <= SEQ_PROBE;
          end else if (!abort && !settling && manual && class_en) begin
            class_start_q <= 1'b1;
            state_q <= SEQ_CLASSIFY;
          end
        end
        SEQ_PROBE: begin
          if (abort) begin
            state_q <= SEQ_IDLE;
          end else if (probe_done) begin
            if (manual) begin
              probe_clear_q <= 1'b1;
              state_q <= SEQ_IDLE;
            end else if (probe_valid && class_en) begin
              class_start_q <= 1'b1;
              state_q <= SEQ_CLASSIFY;
            end else begin
              state_q <= SEQ_IDLE;
            end
          end
        end
        SEQ_CLASSIFY: begin
          if (abort) begin
            state_q <= SEQ_IDLE;
          end else if (class_done) begin
            class_clear_q <= manual;
            power_on_q <= (mode == MODE_AUTO) && !class_bad;
            state_q <= SEQ_IDLE;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Time below threshold counts up; time above counts it back down so a
  // short spike neither resets nor underflows the window.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      below_q <= 32'h0;
      above_q <= 32'h0;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (!(powered && unplug_watch)) begin
        below_q <= 32'h0;
        above_q <= 32'h0;
      end else if (current_above) begin
        above_q <= above_q + 32'h1;
        if (above_q + 32'h1 >= 32'(RESET_CYC)) begin
          below_q <= 32'h0;
        end else if (below_q != 32'h0) begin
          below_q <= below_q - 32'h1;
        end
      end else begin
        above_q <= 32'h0;
        if (below_q >= 32'(WINDOW_CYC - 1)) begin
          timeout_q <= 1'b1;
          below_q <= 32'h0;
        end else begin
          below_q <= below_q + 32'h1;
        end
      end
    end
  end
endmodule : ppc_port

// ### hw/ppc_device.sv
/*
  Power controller register bank: power flags, address byte, modes,
  unplug, probe/classify and fast-off registers, with four port engines.
  Assumes analog comparator and pin inputs are asynchronous, and that
  measurement, cool-down and fault inputs come from logic on clk.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module ppc_device import ppc_pkg::*; #(
  parameter int WINDOW_CYC = UNPLUG_WINDOW_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  ppc_if.device link, // Command link
  input wire logic nv_standalone, // Stored standalone bit
  input wire logic [6:0] nv_bus_address, // Stored bus address
  input wire logic addr_sel_pin, // Address bit 3 pin
  input wire logic fast_off_input_n, // Fast shutdown, active low
  input wire logic [3:0] voltage_good_pin, // Output past good threshold
  input wire logic [3:0] current_probe_pin, // Current above unplug level
  input wire logic [3:0] turn_on_done, // Turn-on sequence complete
  input wire logic [3:0] fault_off, // Fault forces port off
  input wire logic [3:0] cooldown, // Cool-down running
  input wire logic [3:0] probe_done, // Probe finished
  input wire logic [3:0] probe_valid, // Valid resistance seen
  input wire logic [3:0] class_done, // Classification finished
  input wire logic [3:0] class_bad, // Bad classification result
  output logic [3:0] port_power_q, // Power switch per port
  output logic [3:0] probe_start, // Probe start pulse
  output logic [3:0] classify_start, // Classify start pulse
  output logic [3:0] unplug_fault_flag // Unplug fault pulse
);
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic load_q;
  logic standalone_q;
  logic [6:0] addr_q;
  logic [7:0] modes_q;
  logic [3:0] unplug_en_q;
  logic [3:0] fast_sel_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [6:0] own_addr;
  logic match;
  logic wr_hit;
  logic fast_low;
  wire [3:0] good_vec;
  wire [3:0] probe_vec;
  wire [3:0] class_vec;

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign fast_low = !sync2_q[9];
  assign own_addr = {addr_q[6:4], sync2_q[8], addr_q[2:0]};
  assign match = (link.addr == own_addr) || (link.addr == BROADCAST_ADDR)
    || (link.addr == ALERT_ADDR);
  assign wr_hit = link.req && link.wr && match;

  ////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flops before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 10'h200;
      sync2_q <= 10'h200;
    end else begin
      sync1_q <= {fast_off_input_n, addr_sel_pin, voltage_good_pin, current_probe_pin};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stored bits are caught once at the first edge after reset release;
  // later changes wait for the next reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      load_q <= 1'b1;
      standalone_q <= 1'b0;
      addr_q <= 7'h00;
    end else if (load_q) begin
      load_q <= 1'b0;
      standalone_q <= nv_standalone;
      addr_q <= nv_bus_address;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modes_q <= RST_HOST_MODES;
      unplug_en_q <= RST_HOST_UNPLUG;
      fast_sel_q <= RST_HOST_FAST;
    end else if (load_q) begin
      modes_q <= nv_standalone ? RST_SA_MODES : RST_HOST_MODES;
      unplug_en_q <= nv_standalone ? RST_SA_UNPLUG : RST_HOST_UNPLUG;
      fast_sel_q <= nv_standalone ? RST_SA_FAST : RST_HOST_FAST;
    end else if (wr_hit) begin
      case (link.code)
        REG_MODES: modes_q <= link.wdata;
        REG_UNPLUG: unplug_en_q <= link.wdata[3:0];
        REG_FAST_OFF: fast_sel_q <= link.wdata[7:4];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < NPORT; i++) begin : g_port
      logic on_q;
      logic good_q;
      logic probe_en_q;
      logic class_en_q;
      logic held_q;
      logic [1:0] hold_q;
      logic cool_q;
      logic turn_off;
      logic cmd_off;
      logic cmd_on;
      logic en_wr;
      logic auto_on;
      logic probe_clr;
      logic class_clr;
      logic timeout;
      logic [1:0] mode;

      assign mode = modes_q[2*i+1:2*i];
      assign cmd_off = wr_hit && (link.code == REG_POWER_CMD) && link.wdata[CLASS_LSB+i];
      assign cmd_on = wr_hit && (link.code == REG_POWER_CMD) && link.wdata[i];
      assign en_wr = wr_hit && (link.code == REG_PROBE_CLASS);
      assign turn_off = fault_off[i] || timeout || cmd_off || (mode == MODE_OFF)
        || (fast_sel_q[i] && fast_low);
      assign good_vec[i] = good_q;
      assign probe_vec[i] = probe_en_q;
      assign class_vec[i] = class_en_q;

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          on_q <= 1'b0;
          good_q <= 1'b0;
        end else if (turn_off) begin
          on_q <= 1'b0;
          good_q <= 1'b0;
        end else begin
          if (cmd_on || auto_on) begin
            on_q <= 1'b1;
          end
          if (on_q && turn_on_done[i] && sync2_q[4+i]) begin
            good_q <= 1'b1;
          end
        end
      end

      // Host writes beat a same-cycle self-clear so no command is lost
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          probe_en_q <= 1'b0;
          class_en_q <= 1'b0;
          held_q <= 1'b0;
          hold_q <= 2'h0;
          cool_q <= 1'b0;
        end else begin
          cool_q <= cooldown[i];
          if (load_q) begin
            probe_en_q <= nv_standalone && RST_SA_PROBE[i];
            class_en_q <= nv_standalone && RST_SA_PROBE[CLASS_LSB+i];
          end else if (en_wr && !cooldown[i]) begin
            probe_en_q <= link.wdata[i];
            class_en_q <= link.wdata[CLASS_LSB+i];
          end else if (en_wr) begin
            held_q <= 1'b1;
            hold_q <= {link.wdata[CLASS_LSB+i], link.wdata[i]};
          end else if (held_q && cool_q && !cooldown[i]) begin
            held_q <= 1'b0;
            probe_en_q <= hold_q[0];
            class_en_q <= hold_q[1];
          end else if (cmd_off) begin
            probe_en_q <= 1'b0;
            class_en_q <= 1'b0;
          end else begin
            if (probe_clr) begin
              probe_en_q <= 1'b0;
            end
            if (class_clr) begin
              class_en_q <= 1'b0;
            end
          end
        end
      end

      ppc_port #(.WINDOW_CYC(WINDOW_CYC)) u_port (
        .clk(clk),
        .reset(reset),
        .mode(mode),
        .probe_en(probe_en_q),
        .class_en(class_en_q),
        .powered(on_q),
        .cooldown(cooldown[i]),
        .current_above(sync2_q[i]),
        .unplug_watch(unplug_en_q[i]),
        .probe_done(probe_done[i]),
        .probe_valid(probe_valid[i]),
        .class_done(class_done[i]),
        .class_bad(class_bad[i]),
        .probe_start_q(probe_start[i]),
        .class_start_q(classify_start[i]),
        .power_on_q(auto_on),
        .probe_clear_q(probe_clr),
        .class_clear_q(class_clr),
        .timeout_q(timeout)
      );
      assign unplug_fault_flag[i] = timeout;
      assign port_power_q[i] = on_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    case (link.code)
      REG_POWER_FLAGS: rdata_d = {good_vec, port_power_q};
      REG_BUS_ADDR: rdata_d = {standalone_q, addr_q};
      REG_MODES: rdata_d = modes_q;
      REG_UNPLUG: rdata_d = {4'h0, unplug_en_q};
      REG_PROBE_CLASS: rdata_d = {class_vec, probe_vec};
      REG_FAST_OFF: rdata_d = {fast_sel_q, 4'h0};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= link.req && match;
      rdata_q <= (link.req && !link.wr && match) ? rdata_d : 8'h00;
    end
  end
endmodule : ppc_device

// ### hw/ppc_host.sv
/*
  Host controller end: takes orders over a plain register port and
  issues single-byte commands on the link.
  Assumes one strobe per cycle and read data taken the cycle after.
*/
`timescale 1ns/1ps
module ppc_host import ppc_pkg::*; #(
  parameter int GUARD = GUARD_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  ppc_if.host link, // Command link
  input wire logic [2:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata_q // Read data, cycle after strobe
);
  ppc_host_type state_q;
  logic [6:0] target_q;
  logic [7:0] code_q;
  logic [7:0] data_q;
  logic [7:0] resp_q;
  logic op_wr_q;
  logic nack_q;
  logic done_q;
  logic req_q;
  logic [31:0] guard_q;
  logic go;
  logic guarded;

  assign link.req = req_q;
  assign link.wr = op_wr_q;
  assign link.addr = target_q;
  assign link.code = code_q;
  assign link.wdata = data_q;
  assign go = reg_wr && (reg_addr == HREG_CTRL) && (state_q == HOST_IDLE)
    && (reg_wdata[CTRL_GO_WR] || reg_wdata[CTRL_GO_RD]);
  assign guarded = (code_q == REG_MODES) || (code_q == REG_RESTART)
    || (code_q == REG_POWER_CMD) || (code_q == REG_RESET_CMD);

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      target_q <= 7'h00;
      code_q <= 8'h00;
      data_q <= 8'h00;
    end else if (reg_wr && state_q == HOST_IDLE) begin
      case (reg_addr)
        HREG_TARGET: target_q <= reg_wdata[6:0];
        HREG_CODE: code_q <= reg_wdata;
        HREG_DATA: data_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // A probe/class write waits out the guard left by the last mode,
  // restart, power or reset command, counted from that command's answer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= HOST_IDLE;
      op_wr_q <= 1'b0;
      req_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      resp_q <= 8'h00;
      guard_q <= 32'h0;
    end else begin
      req_q <= 1'b0;
      if (guard_q != 32'h0) begin
        guard_q <= guard_q - 32'h1;
      end
      case (state_q)
        HOST_IDLE: begin
          if (go) begin
            op_wr_q <= reg_wdata[CTRL_GO_WR];
            done_q <= 1'b0;
            nack_q <= 1'b0;
            state_q <= HOST_GUARD;
          end
        end
        HOST_GUARD: begin
          if (!(op_wr_q && code_q == REG_PROBE_CLASS && guard_q != 32'h0)) begin
            req_q <= 1'b1;
            state_q <= HOST_WAIT;
          end
        end
        HOST_WAIT: state_q <= HOST_RESP;
        HOST_RESP: begin
          nack_q <= !link.ack;
          done_q <= 1'b1;
          if (link.ack && !op_wr_q) begin
            resp_q <= link.rdata;
          end
          if (link.ack && op_wr_q && guarded) begin
            guard_q <= 32'(GUARD);
          end
          state_q <= HOST_IDLE;
        end
        default: state_q <= HOST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        HREG_TARGET: reg_rdata_q <= {1'b0, target_q};
        HREG_CODE: reg_rdata_q <= code_q;
        HREG_DATA: reg_rdata_q <= data_q;
        HREG_CTRL: reg_rdata_q <= {5'h00, done_q, nack_q, state_q != HOST_IDLE};
        HREG_RDATA: reg_rdata_q <= resp_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end
endmodule : ppc_host

// ### verification/ppc_link_props.sv
/* Link checker: answer timing, addressing, read fields, host spacing.
   Assumes it sits beside the link and gets the host guard count. */
`timescale 1ns/1ps
module ppc_link_props import ppc_pkg::*; #(
  parameter int GUARD = GUARD_CYC
) (
  input wire logic clk, // Clock
  input wire logic reset, // Async reset
  input wire logic req, // Request
  input wire logic wr, // Write
  input wire logic [6:0] addr, // Target
  input wire logic [7:0] code, // Command
  input wire logic ack, // Answer
  input wire logic [7:0] rdata // Read byte
);
  int gcnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Saturates, so a long idle never wraps round to a false short gap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gcnt_q <= GUARD;
    end else if (ack && wr && code inside {REG_MODES, REG_RESTART, REG_POWER_CMD,
                 REG_RESET_CMD}) begin
      gcnt_q <= 0;
    end else if (gcnt_q < GUARD) begin
      gcnt_q <= gcnt_q + 1;
    end
  end
  ////////////////////////////////////////
  AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("ack without req");
  AST_ACK_ONE: assert property (ack |=> !ack) else $error("ack too long");
  AST_BCAST: assert property (req && addr == BROADCAST_ADDR |=> ack)
    else $error("broadcast not answered");
  AST_ALERT: assert property (req && addr == ALERT_ADDR |=> ack)
    else $error("alert address not answered");
  AST_RD_IDLE: assert property (!ack |-> rdata == 8'h00) else $error("rdata not idle");
  AST_FAST_RSV: assert property (ack && !wr && code == REG_FAST_OFF |-> rdata[3:0] == 4'h0)
    else $error("priority low bits set");
  AST_UNPLUG_TOP: assert property (ack && !wr && code == REG_UNPLUG |-> rdata[7:4] == 4'h0)
    else $error("unplug top bits set");
  AST_REQ_GAP: assert property (req |=> !req [*3]) else $error("requests too close");
  AST_GUARD: assert property (req && wr && code == REG_PROBE_CLASS |-> gcnt_q >= GUARD - 1)
    else $error("enable write too soon");
endmodule : ppc_link_props

// ### verification/tb_top.sv
/* Testbench joining host and device ends over the link.
   Assumes a 100 MHz clock and short unplug and guard counts. */
`timescale 1ns/1ps
module tb_top import ppc_pkg::*; ();
  localparam int WIN = 200;
  localparam int GRD = 60;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] ra = 3'h0;
  logic [7:0] rw = 8'h00;
  logic wrs = 1'b0, rds = 1'b0, sa = 1'b0, asel = 1'b0, fon = 1'b1, nk;
  logic [7:0] rq, rv;
  logic [6:0] nva = 7'h20;
  logic [3:0] vg = 4'h0, cp = 4'h0, tod = 4'h0, flt = 4'h0, pd = 4'h0, cd = 4'h0;
  logic [3:0] pw, ps, uf;
  logic [6:0] at [4] = '{7'h28, BROADCAST_ADDR, ALERT_ADDR, 7'h20};
  wire [6:0] dev = {nva[6:4], asel, nva[2:0]};
  int n_errors = 0, samples_checked = 0, seed = 69397, nps = 0;
  ppc_if link ();
  ppc_host #(.GUARD(GRD)) i_ppc_host (.clk(clk), .reset(reset), .link(link.host),
    .reg_addr(ra), .reg_wdata(rw), .reg_wr(wrs), .reg_rd(rds), .reg_rdata_q(rq));
  ppc_device #(.WINDOW_CYC(WIN)) i_ppc_device (.clk(clk), .reset(reset), .link(link.device),
    .nv_standalone(sa), .nv_bus_address(nva), .addr_sel_pin(asel), .fast_off_input_n(fon),
    .voltage_good_pin(vg), .current_probe_pin(cp), .turn_on_done(tod), .fault_off(flt),
    .cooldown(4'h0), .probe_done(pd), .probe_valid(pd), .class_done(cd),
    .class_bad(4'h0), .port_power_q(pw), .probe_start(ps), .classify_start(),
    .unplug_fault_flag(uf));
  ppc_link_props #(.GUARD(GRD)) i_props (.clk(clk), .reset(reset), .req(link.req),
    .wr(link.wr), .addr(link.addr), .code(link.code), .ack(link.ack), .rdata(link.rdata));
  always #5 clk = ~clk;
  always @(negedge clk) if (ps[0] === 1'b1) nps++;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rw <= d;
    wrs <= 1'b1;
    @(posedge clk);
    wrs <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rds <= 1'b1;
    @(posedge clk);
    rds <= 1'b0;
    @(posedge clk);
    d = rq;
  endtask : rreg
  // Polls done, so the guard wait inside the host is covered by the bound
  task automatic cmd(input logic w, input logic [6:0] ad, input logic [7:0] c, d,
                     output logic [7:0] r, output logic nack);
    int i;
    wreg(HREG_TARGET, {1'b0, ad});
    wreg(HREG_CODE, c);
    wreg(HREG_DATA, d);
    wreg(HREG_CTRL, w ? 8'h01 : 8'h02);
    for (i = 0; i < 500; i++) begin
      rreg(HREG_CTRL, r);
      if (r[STAT_DONE] === 1'b1 && r[STAT_BUSY] === 1'b0) break;
    end
    if (i == 500) begin
      n_errors++;
      close_out();
    end
    nack = r[STAT_NACK];
    rreg(HREG_RDATA, r);
  endtask : cmd
  task automatic dread(input logic [7:0] c, e);
    cmd(1'b0, dev, c, 8'h00, rv, nk);
    chk($sformatf("reg %h", c), rv, e);
  endtask : dread
  task automatic dwr(input logic [7:0] c, d);
    cmd(1'b1, dev, c, d, rv, nk);
  endtask : dwr
  ////////////////////////////////////////
  initial begin
    int k;
    int n;
    logic [7:0] d;
    time t0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    for (k = 0; k < 6; k++) dread(8'h10 + 8'(k), k == 1 ? {sa, nva} : 8'h00);
    asel <= 1'b1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 4; k++) begin
      cmd(1'b0, at[k], REG_POWER_FLAGS, 8'h00, rv, nk);
      chk("nack", {7'h00, nk}, {7'h00, k == 3});
    end
    for (k = 0; k < 5; k++) begin
      d = (k < 4) ? {4{2'(k)}} : 8'($random(seed));
      dwr(REG_MODES, d);
      dread(REG_MODES, d);
    end
    dwr(REG_MODES, 8'h55);
    dwr(REG_POWER_CMD, 8'h0F);
    chk("power", {4'h0, pw}, 8'h0F);
    dread(REG_POWER_FLAGS, 8'h0F);
    tod <= 4'hF;
    vg <= 4'hF;
    repeat (4) @(posedge clk);
    tod <= 4'h0;
    vg <= 4'h0;
    dread(REG_POWER_FLAGS, 8'hFF);
    flt <= 4'h1;
    @(posedge clk);
    flt <= 4'h0;
    dread(REG_POWER_FLAGS, 8'hEE);
    dwr(REG_FAST_OFF, 8'h20);
    fon <= 1'b0;
    repeat (4) @(posedge clk);
    dread(REG_FAST_OFF, 8'h20);
    dread(REG_POWER_FLAGS, 8'hCC);
    fon <= 1'b1;
    cp <= 4'h4;
    dwr(REG_UNPLUG, 8'h04);
    cp <= 4'h0;
    repeat (WIN / 2) @(posedge clk);
    cp <= 4'h4;
    repeat (WIN / 4) @(posedge clk);
    cp <= 4'h0;
    for (n = 0; n < 3 * WIN && uf[2] !== 1'b1; n++) @(negedge clk);
    chk("unplug", {7'h00, n > WIN - 8 && n < WIN + 8}, 8'h01);
    dread(REG_POWER_FLAGS, 8'h88);
    dwr(REG_PROBE_CLASS, 8'h01);
    pd <= 4'h1;
    @(posedge clk);
    pd <= 4'h0;
    dread(REG_PROBE_CLASS, 8'h00);
    chk("starts", 8'(nps), 8'h01);
    dwr(REG_PROBE_CLASS, 8'h88);
    dwr(REG_POWER_CMD, 8'h80);
    dread(REG_PROBE_CLASS, 8'h00);
    chk("power", {4'h0, pw}, 8'h00);
    // An enable write right after a mode write must sit out the guard
    dwr(REG_MODES, 8'h55);
    t0 = $time;
    dwr(REG_PROBE_CLASS, 8'h00);
    chk("guard", 8'(($time - t0) / 10 > GRD / 2), 8'h01);
    sa <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    sa <= 1'b0;
    dread(REG_BUS_ADDR, 8'hA0);
    dread(REG_MODES, 8'hFF);
    dread(REG_UNPLUG, 8'h0F);
    dread(REG_PROBE_CLASS, 8'hFF);
    dread(REG_FAST_OFF, 8'h00);
    // Standalone ports probe by themselves; a valid probe and a good class power up
    pd <= 4'h1;
    @(posedge clk);
    pd <= 4'h0;
    cd <= 4'h1;
    @(posedge clk);
    cd <= 4'h0;
    repeat (3) @(posedge clk);
    chk("auto", {4'h0, pw}, 8'h01);
    close_out();
  end
endmodule : tb_top
